/* File: hdl/sdf_filter.sv */
// sinc5 decimate-by-64 filter with result register and ready indication
// Contract
// - modulator sample every six system clocks
// - one result per 64 modulator samples
// - fifth-order 64-tap moving average cascade
// - store result, then pull ready low
// - settled after five conversions, 1920 clocks
// - one result per 384 system clocks
// - 24-bit two's complement, parallel result register
`timescale 1ns/1ps
`default_nettype none
module sdf_filter
    import sdf_pkg::*;
#(
    parameter int RES_W = SDF_RES_W
) (
    // clock and reset
    input  wire logic             sys_clk,
    input  wire logic             rst_n,
    // modulator side
    input  wire logic             mod_bit,       // raw bitstream pin
    output logic                  mod_clk_en,    // one-cycle sample strobe
    // result side
    output logic [RES_W-1:0]      result_q,      // result output register
    output logic                  ready_n_q,     // ready indication, low = fresh
    output logic                  settled_q      // five conversions since reset
);
    // accumulator type
    typedef logic [SDF_ACC_W-1:0] sdf_acc_t;
    // comb output for a frame of all-ones input, 64 to the fifth
    localparam sdf_acc_t FULL_POS = sdf_acc_t'(SDF_DECIM ** SDF_ORDER);

    logic [1:0]       bit_sync_q;                  // pin synchroniser
    logic [2:0]       div_q;                       // system clock divider
    logic [5:0]       dec_q;                       // decimation phase
    sdf_acc_t         integ_q [SDF_ORDER];         // integrator chain
    sdf_acc_t         comb_q  [SDF_ORDER];         // comb delay registers
    sdf_acc_t         comb_v  [SDF_ORDER+1];       // comb stage values
    logic             dec_en;                      // end of decimation frame
    logic             done_q;                      // result stored last cycle
    logic [2:0]       low_cnt_q;                   // ready low length
    logic [2:0]       cnv_cnt_q;                   // conversions since reset
    logic [11:0]      age_q;                       // helper: clocks since reset
    logic [8:0]       per_q;                       // helper: clocks since last result

    // two-flop synchroniser on the modulator bit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            bit_sync_q <= 2'h0;
        end else begin
            bit_sync_q <= {bit_sync_q[0], mod_bit};
        end
    end

    // divide by six for modulator rate
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            div_q <= 3'h0;
        end else if (div_q == SDF_DIV_LAST) begin
            div_q <= 3'h0;
        end else begin
            div_q <= div_q + 3'h1;
        end
    end
    assign mod_clk_en = (div_q == SDF_DIV_LAST);

    // decimation phase counter
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_q <= 6'h0;
        end else if (mod_clk_en) begin
            dec_q <= dec_q + 6'h1;
        end
    end
    assign dec_en = mod_clk_en && (dec_q == SDF_DEC_LAST);

    // integrator chain, input mapped to +1 / -1
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SDF_ORDER; i++) begin
                integ_q[i] <= '0;
            end
        end else if (mod_clk_en) begin
            integ_q[0] <= integ_q[0] + (bit_sync_q[1] ? sdf_acc_t'(1) : '1);
            for (int i = 1; i < SDF_ORDER; i++) begin
                integ_q[i] <= integ_q[i] + integ_q[i-1];
            end
        end
    end

    // comb cascade at the decimated rate
    always_comb begin
        comb_v[0] = integ_q[SDF_ORDER-1];
        for (int i = 0; i < SDF_ORDER; i++) begin
            comb_v[i+1] = comb_v[i] - comb_q[i];
        end
    end

    // comb delay registers
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < SDF_ORDER; i++) begin
                comb_q[i] <= '0;
            end
        end else if (dec_en) begin
            for (int i = 0; i < SDF_ORDER; i++) begin
                comb_q[i] <= comb_v[i];
            end
        end
    end

    // result register: top bits, positive full-scale saturates to the positive limit
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            result_q <= '0;
            done_q   <= 1'b0;
        end else begin
            done_q <= dec_en;
            if (dec_en) begin
                if (!comb_v[SDF_ORDER][SDF_ACC_W-1] && comb_v[SDF_ORDER][SDF_ACC_W-2]) begin
                    result_q <= {1'b0, {(RES_W-1){1'b1}}};
                end else begin
                    result_q <= comb_v[SDF_ORDER][SDF_ACC_W-2 -: RES_W];
                end
            end
        end
    end

    // ready goes low one cycle after the store, for a fixed time
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            ready_n_q <= 1'b1;
            low_cnt_q <= 3'h0;
        end else if (done_q) begin
            ready_n_q <= 1'b0;
            low_cnt_q <= 3'(SDF_RDY_LOW - 1);
        end else if (low_cnt_q != 3'h0) begin
            low_cnt_q <= low_cnt_q - 3'h1;
        end else begin
            ready_n_q <= 1'b1;
        end
    end

    // settled flag after five conversions
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnv_cnt_q <= 3'h0;
            settled_q <= 1'b0;
        end else if (dec_en && !settled_q) begin
            cnv_cnt_q <= cnv_cnt_q + 3'h1;
            settled_q <= (cnv_cnt_q == 3'(SDF_SETTLE_CNV - 1));
        end
    end

    // helper count of clocks since reset, saturating
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            age_q <= 12'h0;
        end else if (age_q != 12'hFFF) begin
            age_q <= age_q + 12'h1;
        end
    end

    // helper count of clocks since the last stored result, restarts on a store
    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            per_q <= 9'h0;
        end else if (dec_en) begin
            per_q <= 9'h0;
        end else begin
            per_q <= per_q + 9'h1;
        end
    end

    // strobe spacing is exactly six clocks
    property p_mod_div;
        @(posedge sys_clk) disable iff (!rst_n)
        mod_clk_en |-> ##1 !mod_clk_en [*5] ##1 mod_clk_en;
    endproperty
    a_mod_div: assert property (p_mod_div) else $error("modulator strobe spacing wrong");

    // results come exactly 384 clocks apart, the first 384 clocks after reset
    property p_rate;
        @(posedge sys_clk) disable iff (!rst_n)
        dec_en == (per_q == 9'(SDF_DECIM * SDF_MOD_DIV - 1));
    endproperty
    a_rate: assert property (p_rate) else $error("result period wrong");

    // decimation frame only on last phase
    property p_decim;
        @(posedge sys_clk) disable iff (!rst_n)
        dec_en |-> ##1 (dec_q == 6'h0);
    endproperty
    a_decim: assert property (p_decim) else $error("decimation phase wrong");

    // ready falls the cycle after a store and lasts six clocks
    property p_ready;
        @(posedge sys_clk) disable iff (!rst_n)
        done_q |=> !ready_n_q [*6] ##1 ready_n_q;
    endproperty
    a_ready: assert property (p_ready) else $error("ready pulse wrong");

    // result stable while ready is low
    property p_result_hold;
        @(posedge sys_clk) disable iff (!rst_n)
        (!ready_n_q && $past(!ready_n_q)) |-> $stable(result_q);
    endproperty
    a_result_hold: assert property (p_result_hold) else $error("result changed during ready");

    // settled rises at the fifth result, 1920 clocks after reset
    property p_settle;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(settled_q) |-> (age_q == 12'(SDF_SETTLE_CLK));
    endproperty
    a_settle: assert property (p_settle) else $error("settling time wrong");

    // a frame at positive full scale saturates to the largest code
    property p_dc;
        @(posedge sys_clk) disable iff (!rst_n)
        (dec_en && (comb_v[SDF_ORDER] == FULL_POS)) |=> (result_q == {1'b0, {(RES_W-1){1'b1}}});
    endproperty
    a_dc: assert property (p_dc) else $error("full-scale result not saturated");

    // no ready pulse before the first complete frame
    property p_first;
        @(posedge sys_clk) disable iff (!rst_n)
        (age_q < 12'(SDF_DECIM * SDF_MOD_DIV)) |-> ready_n_q;
    endproperty
    a_first: assert property (p_first) else $error("ready before first result");

endmodule : sdf_filter
`default_nettype wire

/* File: hdl/sdf_pkg.sv */
// constants for the sinc5 decimation filter
package sdf_pkg;
    localparam int          SDF_MOD_DIV    = 6;      // system clocks per modulator sample
    localparam int          SDF_DECIM      = 64;     // modulator samples per result
    localparam int          SDF_ORDER      = 5;      // sinc order
    localparam int          SDF_RES_W      = 24;     // result width
    localparam int          SDF_ACC_W      = 32;     // 5*log2(64)+2: both full-scale ends fit
    localparam int          SDF_SETTLE_CNV = 5;      // conversions to settle
    localparam int          SDF_SETTLE_CLK = SDF_SETTLE_CNV * SDF_DECIM * SDF_MOD_DIV;
    localparam int          SDF_RDY_LOW    = 6;      // system clocks ready held low
    localparam logic [2:0]  SDF_DIV_LAST   = 3'h5;   // last phase of modulator divider
    localparam logic [5:0]  SDF_DEC_LAST   = 6'h3F;  // last phase of decimation counter
endpackage : sdf_pkg

/* File: tb/sdf_mod_model.sv */
// modulator bitstream model, one new bit after every sample strobe
`timescale 1ns/1ps
`default_nettype none
module sdf_mod_model (
    // clock and sample strobe
    input  wire logic       sys_clk,
    input  wire logic       mod_clk_en,
    // stimulus control
    input  wire logic [1:0] mode,     // 0 low, 1 high, 2 alternate, 3 random
    input  wire logic       rnd_bit,  // random bit from the bench
    // bitstream pin
    output logic            mod_bit
);
    logic alt_q = 1'b0;  // phase of the alternating pattern
    initial mod_bit = 1'b0;
    // bit changes just after the strobe, so it is stable for a whole sample
    always @(posedge sys_clk) begin
        if (mod_clk_en) begin
            alt_q <= ~alt_q;
            case (mode)
                2'h0: mod_bit <= 1'b0;
                2'h1: mod_bit <= 1'b1;
                2'h2: mod_bit <= alt_q;
                default: mod_bit <= rnd_bit;
            endcase
        end
    end
endmodule : sdf_mod_model
`default_nettype wire

/* File: tb/testbench.sv */
// self-checking bench for the sinc5 decimation filter
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import sdf_pkg::*;
    logic        sys_clk = 1'b0;       // system clock
    logic        rst_n   = 1'b0;       // reset, active low
    logic [1:0]  mode    = 2'h1;       // modulator stimulus mode
    logic        rnd_bit = 1'b0;       // random modulator bit
    logic [31:0] seed    = 32'h4A339C9D; // xorshift state
    logic        mod_bit, mod_clk_en, ready_n_q, settled_q;
    logic [23:0] result_q;
    logic [24:0] exp_q[$];             // bit 24 set: compare, clear: discard
    logic        rdy_p   = 1'b1;       // ready as seen one cycle ago
    int          err_count = 0, n_tests = 0, nf = 0, gap = 0, sgap = 0, low = 0;
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction : xs
    always #4 sys_clk = ~sys_clk;
    // random source feeding the modulator model
    always @(posedge sys_clk) begin
        seed    <= xs(seed);
        rnd_bit <= seed[7];
    end
    sdf_filter u_sdf_filter (.sys_clk(sys_clk), .rst_n(rst_n), .mod_bit(mod_bit),
        .mod_clk_en(mod_clk_en), .result_q(result_q), .ready_n_q(ready_n_q),
        .settled_q(settled_q));
    sdf_mod_model u_sdf_mod_model (.sys_clk(sys_clk), .mod_clk_en(mod_clk_en),
        .mode(mode), .rnd_bit(rnd_bit), .mod_bit(mod_bit));
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("unexpected %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : check
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : wrap_up
    // set a mode, skip the transient results, then expect n settled ones
    task automatic run(input string nm, input logic [1:0] m, input int n, input logic [23:0] v);
        int i;
        mode <= m;
        repeat (5) exp_q.push_back(25'h0);
        repeat (n) exp_q.push_back({1'b1, v});
        for (i = 0; i < 20000 && exp_q.size() > 0; i++) @(posedge sys_clk);
        if (exp_q.size() > 0) begin
            err_count++;
            wrap_up();
        end
        $display("test %s done", nm);
    endtask : run
    // watcher: strobe spacing, result spacing, ready width, scoreboard
    always @(negedge sys_clk) begin
        if (!rst_n) begin
            nf = 0;
            gap = 0;
            sgap = 0;
            low = 0;
            rdy_p = 1'b1;
        end else begin
            gap++;
            sgap++;
            if (mod_clk_en === 1'b1) begin
                check("strobe gap", sgap, 6);
                sgap = 0;
            end
            if (ready_n_q === 1'b0) low++;
            if (rdy_p === 1'b1 && ready_n_q === 1'b0) begin
                nf++;
                check("result gap", gap, (nf == 1) ? 386 : 384);
                check("settled", {31'h0, settled_q}, 32'(nf >= 5));
                gap = 0;
                if (exp_q.size() > 0 && exp_q[0][24])
                    check("result", {8'h0, result_q}, {8'h0, exp_q[0][23:0]});
                if (exp_q.size() > 0) void'(exp_q.pop_front());
            end
            if (rdy_p === 1'b0 && ready_n_q === 1'b1) begin
                check("ready low", low, 6);
                low = 0;
            end
            rdy_p = ready_n_q;
        end
    end
    // main sequence
    initial begin
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        run("power_up", 2'h1, 3, 24'h7FFFFF);
        repeat (seed[8:0]) @(posedge sys_clk);
        run("step_low", 2'h0, 2, 24'h800000);
        run("alternate", 2'h2, 2, 24'h000000);
        mode <= 2'h3;
        repeat (384 + seed[9:0]) @(posedge sys_clk);
        run("random_to_high", 2'h1, 1, 24'h7FFFFF);
        rst_n <= 1'b0;
        repeat (3) @(negedge sys_clk);
        check("reset result", {8'h0, result_q}, 32'h0);
        check("reset ready", {31'h0, ready_n_q}, 32'h1);
        check("reset settled", {31'h0, settled_q}, 32'h0);
        @(posedge sys_clk);
        rst_n <= 1'b1;
        run("mid_reset", 2'h1, 1, 24'h7FFFFF);
        wrap_up();
    end
endmodule : testbench
`default_nettype wire
